/* File: design/ppc_pkg.sv */
/*
 * Constants, field layout and state encoding of the parallel port control
 * and mode block. Assumes one 50 MHz clock and an APB register bus.
 */
// =============================================================================
// Operation
// - With the enable bit clear the port makes no off-chip access at all.
// - Stop-in-idle set halts the port while the device idles; clear keeps it running.
// - Multiplex field picks separate, low byte muxed, all 16 muxed, or low byte only.
// - Write-strobe pin enable decides whether the port drives the write/enable pin.
// - Read-strobe pin enable decides whether the port drives the read or R/W pin.
// - Chip-select field 10 makes the shared pin a chip select; 00/01 address bit 14.
// - Address-latch polarity sets both latch strobes active-high or active-low.
// - Chip-select polarity sets the chip-select output active-high or active-low.
// - Write polarity sets write strobe level; in master mode 1 the enable strobe.
// - Read polarity sets read strobe level; in master mode 1 the R/W strobe.
// - Chip-select and polarity settings do not touch pins used as address lines.
// - In master modes the busy bit reads 1 during a transfer, 0 when idle.
// - Interrupt mode: none, every cycle end, or buffer 3 / address 3 access.
// - Increment mode 01 adds four (bits 10:2 step), 10 subtracts four, 00 holds the address.
// - Increment mode 11 auto-increments the slave buffers in legacy slave mode.
// - Address bit 14 is left out of stepping when its pin is a chip select.
// - Mode 11 is master with R/W and enable strobes; 10 uses separate strobes.
// - Mode 01 is the addressed enhanced slave; 00 the legacy slave.
// - Setup wait gives 1 to 4 bus periods of setup and of address phase.
// - Strobe wait gives a strobe of field value plus one bus periods.
// - Strobe wait 0000 forces setup 1, hold 1 on writes, hold 0 on reads.
// - Control and mode have clear, set and invert aliases at +4, +8, +C.
// - Hold wait gives 1 to 4 periods after writes and 0 to 3 after reads.
// =============================================================================
package ppc_pkg;
	// Register offsets and alias offsets
	localparam logic [7:0] OFF_CON   = 8'h00;
	localparam logic [7:0] OFF_MODE  = 8'h10;
	localparam logic [7:0] OFF_ADDR  = 8'h20;
	localparam logic [7:0] OFF_DOUT  = 8'h30;
	localparam logic [7:0] OFF_DIN   = 8'h40;
	localparam logic [3:0] ALIAS_CLR = 4'h4;
	localparam logic [3:0] ALIAS_SET = 4'h8;
	localparam logic [3:0] ALIAS_INV = 4'hC;
	// Reset values and writable masks
	localparam logic [15:0] CON_RESET  = 16'h0000;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] CON_WMASK  = 16'hBFEB;
	localparam logic [15:0] MODE_WMASK = 16'h7BFF;
	localparam logic [15:0] ADDR_WMASK = 16'h47FF;
	// Field positions
	localparam int CON_ON = 15;
	localparam int CON_STOP_IN_IDLE = 13;
	localparam int CON_MUX = 11;
	localparam int CON_WREN = 9;
	localparam int CON_RDEN = 8;
	localparam int CON_CSF = 6;
	localparam int CON_ALP = 5;
	localparam int CON_CSP = 3;
	localparam int CON_WRITE_STROBE_POLARITY = 1;
	localparam int CON_READ_STROBE_POLARITY = 0;
	localparam int MODE_BUSY = 15;
	localparam int MODE_IRQ_MODE = 13;
	localparam int MODE_INCREMENT_MODE = 11;
	localparam int MODE_SEL = 8;
	localparam int MODE_SETUP = 6;
	localparam int MODE_STROBE = 2;
	localparam int MODE_HOLD = 0;
	// Field codes
	localparam logic [1:0] MUX_SEP = 2'h0;
	localparam logic [1:0] MUX_ALL16 = 2'h2;
	localparam logic [1:0] CSF_CS = 2'h2;
	localparam logic [1:0] PM_LEGACY = 2'h0;
	localparam logic [1:0] PM_ENH = 2'h1;
	localparam logic [1:0] PM_MST1 = 2'h3;
	localparam logic [1:0] IRQ_NONE = 2'h0;
	localparam logic [1:0] IRQ_CYCLE = 2'h1;
	localparam logic [1:0] IRQ_BUF = 2'h2;
	localparam logic [1:0] INC_UP = 2'h1;
	localparam logic [1:0] INC_DOWN = 2'h2;
	localparam logic [1:0] INC_BUF = 2'h3;
	// Wait states count peripheral-bus clock periods
	localparam int CLK_PERIOD_NS = 20;
	localparam int PB_PERIOD_NS = 20;
	localparam logic [3:0] PB_DIV = 4'(PB_PERIOD_NS / CLK_PERIOD_NS);
	// Master sequencer states, Gray along the usual path
	typedef enum logic [2:0] {
		PPC_IDLE = 3'h0, PPC_ALO = 3'h1, PPC_AHI = 3'h3,
		PPC_SETUP = 3'h2, PPC_STROBE = 3'h6, PPC_HOLD = 3'h7
	} ppc_state_t;
endpackage : ppc_pkg

/* File: design/ppc_top.sv */
/*
 * Parallel port: APB register slave, master sequencer with wait states,
 * and a small slave buffer. Assumes pins are resolved by the surroundings
 * and that cpu_idle comes from logic on pclk.
 */
`timescale 1ns/1ps
module ppc_top #(
	parameter int BUF_DEPTH = 4
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Device power state
	input  wire logic        cpu_idle,
	// Data pins
	input  wire logic [7:0]  port_data_in,
	output logic      [7:0]  port_data_out,
	output logic             port_data_oe,
	// Address and control pins driven in master modes
	output logic      [8:0]  port_addr_lines,
	output logic             addr_latch_low,
	output logic             addr_latch_high,
	output logic             chip_select_out,
	output logic             addr_oe,
	// Strobe pins, inputs in slave modes
	input  wire logic        read_strobe_in,
	output logic             read_strobe,
	output logic             read_strobe_oe,
	input  wire logic        write_strobe_in,
	output logic             write_strobe,
	output logic             write_strobe_oe,
	input  wire logic        chip_select_in,
	input  wire logic [1:0]  slave_addr_in,
	// Interrupt request pulse
	output logic             irq_req
);
	import ppc_pkg::*;

	localparam int SW = $clog2(BUF_DEPTH);

	// =========================================================================
	// Helpers
	// Apply a plain, clear, set or invert write to writable bits only
	function automatic logic [15:0] ppc_alias(input logic [15:0] old, input logic [15:0] wd,
		input logic [3:0] sub, input logic [15:0] mask);
		logic [15:0] v;
		case (sub)
			ALIAS_CLR: v = old & ~wd;
			ALIAS_SET: v = old | wd;
			ALIAS_INV: v = old ^ wd;
			default:   v = wd;
		endcase
		return (v & mask) | (old & ~mask);
	endfunction : ppc_alias

	// Step the address; bit 14 joins the counter only when it is an address
	function automatic logic [15:0] ppc_step(input logic [15:0] a, input logic [1:0] inc,
		input logic cs_pin);
		logic [9:0]  f;
		logic [15:0] r;
		f = {a[14], a[10:2]};
		r = a;
		if (inc == INC_UP) begin
			f = f + 10'h001;
		end else if (inc == INC_DOWN) begin
			f = f - 10'h001;
		end
		r[10:2] = f[8:0];
		if (!cs_pin) begin
			r[14] = f[9];
		end
		return r;
	endfunction : ppc_step

	// =========================================================================
	// State
	logic [15:0]   con;
	logic [15:0]   mode_r;
	logic [15:0]   addr;
	logic [7:0]    dout;
	logic [7:0]    din;
	logic [7:0]    buf_mem [BUF_DEPTH];
	logic [SW-1:0] ptr;
	ppc_state_t    state;
	logic [4:0]    cnt;
	logic          is_rd;
	logic [3:0]    div_cnt;
	logic [12:0]   sin1;
	logic [12:0]   sin2;
	logic [2:0]    s_prev;
	logic [1:0]    rd_pipe;

	// Control fields
	wire       on     = con[CON_ON];
	wire       halt   = con[CON_STOP_IN_IDLE] & cpu_idle;
	wire       run    = on & ~halt;
	wire [1:0] mux    = con[CON_MUX +: 2];
	wire [1:0] chip_select_function    = con[CON_CSF +: 2];
	wire       addr_latch_polarity    = con[CON_ALP];
	wire       csp    = con[CON_CSP];
	wire       write_strobe_polarity   = con[CON_WRITE_STROBE_POLARITY];
	wire       read_strobe_polarity   = con[CON_READ_STROBE_POLARITY];
	wire [1:0] irq_mode   = mode_r[MODE_IRQ_MODE +: 2];
	wire [1:0] increment_mode   = mode_r[MODE_INCREMENT_MODE +: 2];
	wire [1:0] pmode  = mode_r[MODE_SEL +: 2];
	wire [1:0] wait_b = mode_r[MODE_SETUP +: 2];
	wire [3:0] wait_m = mode_r[MODE_STROBE +: 4];
	wire [1:0] wait_e = mode_r[MODE_HOLD +: 2];
	wire       master = pmode[1];
	wire       cs_pin = (chip_select_function == CSF_CS);
	wire       busy   = (state != PPC_IDLE);

	// =========================================================================
	// APB decode; every access completes one cycle after its setup cycle
	wire        setup_ph = psel & ~penable;
	wire        wr_acc   = psel & penable & pready & pwrite;
	wire        hit_con  = (paddr[7:4] == OFF_CON[7:4]);
	wire        hit_mode = (paddr[7:4] == OFF_MODE[7:4]);
	wire        hit_addr = (paddr == OFF_ADDR);
	wire        hit_dout = (paddr == OFF_DOUT);
	wire        hit_din  = (paddr == OFF_DIN);
	wire        mapped   = (hit_con | hit_mode | hit_addr | hit_dout | hit_din)
	                       & (paddr[1:0] == 2'h0);
	wire [15:0] mode_rd  = {busy, mode_r[14:0]};
	wire [31:0] buf_word = {buf_mem[3 % BUF_DEPTH], buf_mem[2 % BUF_DEPTH],
	                        buf_mem[1 % BUF_DEPTH], buf_mem[0]};
	wire [31:0] din_rd   = master ? {24'h000000, din} : buf_word;
	wire [31:0] rd_word  = hit_con  ? {16'h0000, con} :
	                       hit_mode ? {16'h0000, mode_rd} :
	                       hit_addr ? {16'h0000, addr} :
	                       hit_dout ? {24'h000000, dout} :
	                       hit_din  ? din_rd : 32'h00000000;

	// Register updates, aliases on control and mode only
	wire        start    = wr_acc & (hit_dout | hit_din) & master & run & ~busy;
	wire [15:0] next_con = (wr_acc & hit_con)
		? ppc_alias(con, pwdata[15:0], paddr[3:0], CON_WMASK) : con;
	wire [15:0] next_mode = (wr_acc & hit_mode)
		? ppc_alias(mode_r, pwdata[15:0], paddr[3:0], MODE_WMASK) : mode_r;

	// =========================================================================
	// Bus-period divider: wait states tick on this enable
	wire pb_tick = (div_cnt == PB_DIV - 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 4'h0;
		end else begin
			div_cnt <= (pb_tick || !run) ? 4'h0 : div_cnt + 4'h1;
		end
	end

	// =========================================================================
	// Phase lengths in bus periods
	wire       fast       = (wait_m == 4'h0);
	wire [4:0] setup_len  = fast ? 5'h01 : {3'h0, wait_b} + 5'h01;
	wire [4:0] strobe_len = {1'h0, wait_m} + 5'h01;
	wire [4:0] hold_wr    = fast ? 5'h01 : {3'h0, wait_e} + 5'h01;
	wire [4:0] hold_rd    = fast ? 5'h00 : {3'h0, wait_e};
	wire [4:0] hold_len   = is_rd ? hold_rd : hold_wr;
	wire [4:0] cur_len    = (state == PPC_STROBE) ? strobe_len :
	                        (state == PPC_HOLD) ? hold_len : setup_len;
	wire       phase_done = pb_tick & (cnt == cur_len - 5'h01);

	// Sequencer next state: address phases, setup, strobe, hold
	ppc_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			PPC_IDLE:   if (start) next_state = (mux == MUX_SEP) ? PPC_SETUP : PPC_ALO;
			PPC_ALO:    if (phase_done) next_state = (mux == MUX_ALL16) ? PPC_AHI : PPC_SETUP;
			PPC_AHI:    if (phase_done) next_state = PPC_SETUP;
			PPC_SETUP:  if (phase_done) next_state = PPC_STROBE;
			PPC_STROBE: if (phase_done) next_state = (hold_len == 5'h00) ? PPC_IDLE : PPC_HOLD;
			PPC_HOLD:   if (phase_done) next_state = PPC_IDLE;
			default:    next_state = PPC_IDLE;
		endcase
	end

	wire end_cyc  = run & busy & (next_state == PPC_IDLE);
	wire rd_latch = run & is_rd & (state == PPC_STROBE) & phase_done;

	// Sequencer registers; halting freezes it, disabling aborts it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= PPC_IDLE;
			cnt   <= 5'h00;
			is_rd <= 1'b0;
		end else if (!on) begin
			state <= PPC_IDLE;
			cnt   <= 5'h00;
		end else if (run) begin
			state <= next_state;
			cnt   <= (next_state != state) ? 5'h00 : (pb_tick ? cnt + 5'h01 : cnt);
			if (start) begin
				is_rd <= hit_din;
			end
		end
	end

	// =========================================================================
	// Input synchroniser for every pin the port samples
	wire [12:0] pin_raw = {chip_select_in, read_strobe_in, write_strobe_in,
	                       slave_addr_in, port_data_in};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sin1 <= 13'h0000;
			sin2 <= 13'h0000;
		end else begin
			sin1 <= pin_raw;
			sin2 <= sin1;
		end
	end

	// Slave side: strobes compared against their programmed levels
	wire          s_cs     = (sin2[12] == csp);
	wire          s_rd     = (sin2[11] == read_strobe_polarity);
	wire          s_wr     = (sin2[10] == write_strobe_polarity);
	wire          slave_on = run & ~master;
	wire          s_wr_end = slave_on & s_prev[0] & s_prev[2] & ~(s_wr & s_cs);
	wire          s_rd_end = slave_on & s_prev[1] & s_prev[2] & ~(s_rd & s_cs);
	wire          s_end    = s_wr_end | s_rd_end;
	wire [SW-1:0] slot     = (pmode == PM_ENH) ? sin2[8 +: SW] : ptr;
	wire          buf_step = s_end & (increment_mode == INC_BUF) & (pmode == PM_LEGACY);

	// Slave strobe history, buffer and pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_prev <= 3'h0;
			ptr    <= '0;
		end else begin
			s_prev <= {s_cs, s_rd, s_wr};
			if (buf_step) begin
				ptr <= ptr + 1'b1;
			end
		end
	end

	// Buffer holds bytes written by the external master or by software
	always_ff @(posedge pclk) begin
		if (s_wr_end) begin
			buf_mem[slot] <= sin2[7:0];
		end else if (wr_acc && hit_dout && !master) begin
			for (int i = 0; i < BUF_DEPTH; i++) begin
				buf_mem[i] <= pwdata[8 * (i % 4) +: 8];
			end
		end
	end

	// Interrupt request per mode; buffer mode fires on slot 3
	wire next_irq = (irq_mode == IRQ_CYCLE) ? (end_cyc | s_end) :
	                (irq_mode == IRQ_BUF) ? (s_end & (slot == SW'(3 % BUF_DEPTH))) :
	                1'b0;

	// =========================================================================
	// Registers reached by software, plus read data capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			con    <= CON_RESET;
			mode_r <= MODE_RESET;
			addr   <= ADDR_RESET;
			dout   <= 8'h00;
			din    <= 8'h00;
			rd_pipe <= 2'h0;
		end else begin
			con    <= next_con;
			rd_pipe <= {rd_pipe[0], rd_latch};
			mode_r <= next_mode;
			if (wr_acc && hit_addr) begin
				addr <= pwdata[15:0] & ADDR_WMASK;
			end else if (end_cyc) begin
				addr <= ppc_step(addr, increment_mode, cs_pin);
			end
			if (wr_acc && hit_dout) begin
				dout <= pwdata[7:0];
			end
			if (rd_pipe[1]) begin                                           // Pins reach sin2 two cycles late
				din <= sin2[7:0];
			end
		end
	end

	// =========================================================================
	// Pin values; every pin is registered, so pins trail the state by a cycle
	wire addr_ph  = (state == PPC_ALO) | (state == PPC_AHI);
	wire data_ph  = busy & ~addr_ph & ~is_rd;
	wire strobing = (state == PPC_STROBE);
	wire s_drive  = slave_on & s_rd & s_cs;
	wire mst_on   = on & master;

	wire [7:0] next_dout = (state == PPC_ALO) ? addr[7:0] :
	                       (state == PPC_AHI) ? addr[15:8] :
	                       master ? dout : buf_mem[slot];
	wire next_doe = (mst_on & (addr_ph | data_ph)) | (on & s_drive);
	// Latch pins are plain address lines when nothing is multiplexed
	wire next_all = (mux == MUX_SEP) ? addr[0] :
	                ((state == PPC_ALO) ? addr_latch_polarity : ~addr_latch_polarity);
	wire next_alh = (mux == MUX_SEP) ? addr[1] :
	                ((state == PPC_AHI) ? addr_latch_polarity : ~addr_latch_polarity);
	wire next_cs  = cs_pin ? (busy ? csp : ~csp) : addr[14];
	// Mode 1 uses a direction line plus enable; mode 2 separate strobes
	wire next_rds = (pmode == PM_MST1) ? ((busy & is_rd) ? read_strobe_polarity : ~read_strobe_polarity)
	                                   : ((strobing & is_rd) ? read_strobe_polarity : ~read_strobe_polarity);
	wire next_wrs = (pmode == PM_MST1) ? (strobing ? write_strobe_polarity : ~write_strobe_polarity)
	                                   : ((strobing & ~is_rd) ? write_strobe_polarity : ~write_strobe_polarity);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_data_out   <= 8'h00;
			port_data_oe    <= 1'b0;
			port_addr_lines <= 9'h000;
			addr_latch_low  <= 1'b0;
			addr_latch_high <= 1'b0;
			chip_select_out <= 1'b0;
			addr_oe         <= 1'b0;
			read_strobe     <= 1'b0;
			read_strobe_oe  <= 1'b0;
			write_strobe    <= 1'b0;
			write_strobe_oe <= 1'b0;
			irq_req         <= 1'b0;
		end else begin
			port_data_out   <= next_dout;
			port_data_oe    <= next_doe;
			port_addr_lines <= addr[10:2];
			addr_latch_low  <= next_all;
			addr_latch_high <= next_alh;
			chip_select_out <= next_cs;
			addr_oe         <= mst_on;
			read_strobe     <= next_rds;
			read_strobe_oe  <= mst_on & con[CON_RDEN];
			write_strobe    <= next_wrs;
			write_strobe_oe <= mst_on & con[CON_WREN];
			irq_req         <= next_irq;
		end
	end

	// APB answer registered from the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			prdata  <= (setup_ph && mapped) ? rd_word : 32'h00000000;
		end
	end

	// =========================================================================
	// Checks; a strobe counter measures the strobe phase
	logic [4:0] stb_seen;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stb_seen <= 5'h00;
		end else begin
			stb_seen <= strobing ? stb_seen + {4'h0, run} : 5'h00;          // Holds while halted
		end
	end

	off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!on |=> !port_data_oe && !addr_oe && !read_strobe_oe && !write_strobe_oe)
		else $error("port drives pins while disabled");
	idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(on && halt) |=> (state == $past(state)) && (cnt == $past(cnt)))
		else $error("sequencer moved while halted in idle");
	busy_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> busy ##0 (next_state == state || !pb_tick || cnt == cur_len - 5'h01))
		else $error("busy did not rise on start");
	strobe_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		(strobing && run && next_state != PPC_STROBE && PB_DIV == 4'h1)
		|-> (stb_seen + 5'h01 == strobe_len))
		else $error("strobe phase has wrong length");
	fast_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(strobing && run && phase_done && fast && is_rd) |=> state == PPC_IDLE)
		else $error("read hold not zero with strobe wait 0");
	mux_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == PPC_ALO && mst_on) |=> port_data_oe && port_data_out == $past(addr[7:0]))
		else $error("low address byte not on data lines");
	cs_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cs_pin && busy) |=> chip_select_out == $past(csp))
		else $error("chip select level wrong");
	no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_mode == IRQ_NONE) |=> !irq_req)
		else $error("interrupt raised in mode 00");
	addr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(end_cyc && increment_mode == INC_UP && !cs_pin && !wr_acc)
		|=> {addr[14], addr[10:2]} == $past({addr[14], addr[10:2]}) + 10'h001)
		else $error("address did not increment");
endmodule : ppc_top

/* File: dv/ppc_periph.sv */
/*
 * Behavioural model of the external peripheral on the parallel port pins.
 * Assumes chip select and read direction arrive already decoded to active high.
 */
`timescale 1ns/1ps
// =============================================================================
// Peripheral model
module ppc_periph (
	// Pins as seen by the peripheral
	input  wire logic       pclk,
	input  wire logic       sel,
	input  wire logic       rd_act,
	input  wire logic [7:0] din,
	input  wire logic       din_oe,
	output logic      [7:0] dout
);
	logic [7:0] mem;
	initial mem = 8'hA5;
	// Answers at once while read; a released bus shows the inverse so stale data never matches
	assign dout = (sel && rd_act) ? mem : ~mem;
	// Keeps the last byte driven while selected
	always @(posedge pclk) begin
		if (sel && din_oe) mem <= din;
	end
endmodule : ppc_periph

/* File: dv/tb_top.sv */
/*
 * Self-checking bench: APB master tasks and master-mode scenarios.
 * Assumes the pin map and offsets of ppc_pkg; APB answers may take any number of cycles.
 */
`timescale 1ns/1ps
// =============================================================================
// Bench top
module tb_top;
	import ppc_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, idle = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, data_oe, addr_oe, cs, all, alh, irq_req;
	logic [7:0]  pdi, pdo;
	logic [8:0]  alines;
	logic        rs, rs_oe, ws, ws_oe, exp_pol;
	int          mismatches = 0, num_checks = 0, wr_cnt = 0, rd_cnt = 0, bad_cs = 0, w0;
	int          irq_cnt = 0;
	// Clock at 50 MHz
	initial forever #10 pclk = ~pclk;
	ppc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_idle(idle), .port_data_in(pdi), .port_data_out(pdo),
		.port_data_oe(data_oe), .port_addr_lines(alines), .addr_latch_low(all),
		.addr_latch_high(alh), .chip_select_out(cs), .addr_oe(addr_oe),
		.read_strobe_in(1'b1), .read_strobe(rs), .read_strobe_oe(rs_oe),
		.write_strobe_in(1'b1), .write_strobe(ws), .write_strobe_oe(ws_oe),
		.chip_select_in(1'b0), .slave_addr_in(2'h0), .irq_req(irq_req));
	ppc_periph u_periph (.pclk(pclk), .sel(cs === 1'b1 && addr_oe === 1'b1),
		.rd_act(rs === 1'b0 && rs_oe === 1'b1), .din(pdo), .din_oe(data_oe === 1'b1),
		.dout(pdi));
	// Strobe monitors; a write strobe seen without chip select is counted as bad
	always @(posedge pclk) begin
		if (ws_oe === 1'b1 && ws === exp_pol) wr_cnt <= wr_cnt + 1;
		if (ws_oe === 1'b1 && ws === exp_pol && cs !== 1'b1) bad_cs <= bad_cs + 1;
		if (rs_oe === 1'b1 && rs === 1'b0) rd_cnt <= rd_cnt + 1;
		if (irq_req === 1'b1) irq_cnt <= irq_cnt + 1;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk
	// One APB transfer; waits for pready, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin @(posedge pclk); end while (pready !== 1'b1);
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic wait_idle();
		int n;
		n = 0;
		do begin apb(0, OFF_MODE, 0); n++; end while (rd[15] !== 1'b0 && n < 40);
		chk("busy clears", 1'b0, rd[15]);
	endtask : wait_idle
	// Reset values, aliases and an unmapped place
	task automatic t_regs();
		apb(0, OFF_CON, 0); chk("con reset", 32'h0, rd);
		apb(0, OFF_MODE, 0); chk("mode reset", 32'h0, rd);
		apb(1, OFF_CON, 32'h9388); apb(1, OFF_CON + ALIAS_SET, 32'h2);
		apb(0, OFF_CON, 0); chk("con set alias", 32'h938A, rd);
		apb(0, 8'h50, 0); chk("unmapped error", 1'b1, err);
	endtask : t_regs
	// Master mode 2 write, 16 address bits muxed: strobe, chip select, busy, idle freeze, increment
	task automatic t_mst2();
		apb(1, OFF_CON + ALIAS_INV, 32'h2002); exp_pol = 1'b0;
		apb(1, OFF_ADDR, 32'h10); apb(1, OFF_MODE, 32'h0A54); w0 = wr_cnt;
		apb(1, OFF_DOUT, 32'h3C); apb(0, OFF_MODE, 0);
		chk("busy in transfer", 1'b1, rd[15]);
		idle <= 1'b1; repeat (20) @(posedge pclk);
		apb(0, OFF_MODE, 0); chk("busy frozen in idle", 1'b1, rd[15]);
		idle <= 1'b0;
		wait_idle();
		chk("strobe length", 6, wr_cnt - w0);
		chk("cs with strobe", 0, bad_cs);
		apb(0, OFF_ADDR, 0); chk("address up", 32'h14, rd);
		chk("addr pins", 9'h005, alines);
		chk("data latched", 8'h3C, u_periph.mem);
	endtask : t_mst2
	// Master mode 1 read, zero waits, enable high, irq per cycle, decrement, read data
	task automatic t_mst1();
		apb(1, OFF_CON + ALIAS_INV, 32'h3002); exp_pol = 1'b1;
		apb(1, OFF_MODE, 32'h3300); w0 = wr_cnt;
		apb(1, OFF_DIN, 32'h0); wait_idle();
		apb(0, OFF_ADDR, 0); chk("address down", 32'h10, rd);
		chk("enable strobe", 1, wr_cnt - w0);
		chk("rw strobe seen", 1'b1, rd_cnt > 0);
		chk("irq per cycle", 1, irq_cnt);
		apb(0, OFF_DIN, 0); chk("read data", 32'h3C, rd);
	endtask : t_mst1
	// Port disabled: no strobe and no busy
	task automatic t_off();
		apb(1, OFF_CON + ALIAS_CLR, 32'h8000); apb(1, OFF_CON + ALIAS_INV, 32'h8);
		apb(0, OFF_CON, 0); chk("con inv alias", 32'h0382, rd);
		w0 = wr_cnt; apb(1, OFF_DOUT, 32'h55); apb(0, OFF_MODE, 0);
		chk("busy when off", 1'b0, rd[15]);
		repeat (20) @(posedge pclk);
		chk("no strobe off", 0, wr_cnt - w0);
	endtask : t_off
	task automatic report_and_stop();
		if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial begin
		exp_pol = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs(); t_mst2(); t_mst1(); t_off();
		report_and_stop();
	end
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
endmodule : tb_top
